// ==== shared/gmt_pkg.sv ====
// Package for the gated modulo timer: register offsets, field positions,
// reset values, clock select codes and divider counts.
// Assumes a 10 MHz system clock driving the block.
package gmt_pkg;
    localparam int unsigned sys_clk_hz = 10000000;
    localparam int unsigned rate0_hz = 100000;
    localparam int unsigned rate1_hz = 10000;
    localparam int unsigned rate2_hz = 2000;
    localparam int unsigned rate3_hz = 1000;
    localparam int unsigned div0_cycles = sys_clk_hz / rate0_hz;
    localparam int unsigned div1_cycles = sys_clk_hz / rate1_hz;
    localparam int unsigned div2_cycles = sys_clk_hz / rate2_hz;
    localparam int unsigned div3_cycles = sys_clk_hz / rate3_hz;
    localparam int unsigned div_width = 14;

    localparam logic [7:0] addr_match = 8'h1a;
    localparam logic [7:0] addr_clkrun = 8'h2b;
    localparam logic [7:0] addr_mode = 8'h2c;
    localparam logic [7:0] addr_count = 8'h2d;

    localparam int unsigned clk_sel_lo_bit = 0;
    localparam int unsigned clk_sel_hi_bit = 1;
    localparam int unsigned count_clear_bit = 2;
    localparam int unsigned run_enable_bit = 3;
    localparam int unsigned gate_mode_bit = 0;
    localparam int unsigned open_edge_bit = 1;
    localparam int unsigned close_edge_bit = 2;
    localparam int unsigned overflow_bit = 3;

    localparam logic [3:0] clkrun_reset = 4'h0;
    localparam logic [3:0] mode_reset = 4'h0;
    localparam logic [7:0] match_reset = 8'hff;

    typedef enum logic [1:0] {
        sel_100k = 2'b00,
        sel_10k = 2'b01,
        sel_2k = 2'b10,
        sel_1k = 2'b11
    } clk_sel_t;
endpackage

// ==== verification/gated_modulo_timer8_bench.sv ====
// Self-checking bench for the gated modulo timer.
// Assumes the timer package and the gate source model are compiled first.
`timescale 1ns/1ps
module gated_modulo_timer8_bench;
    import gmt_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_rst_i = 0, wr_i = 0, rd_i = 0, rd_valid_o, gate, irq;
    logic g_start = 0, g_high = 1;
    logic [7:0] addr_i = 8'h00, wdat = 8'h00, cnt, data_buffer_o, timer_count_value_o;
    logic [15:0] g_width = 16'h0000;
    int errors = 0, comparisons = 0, cycles = 0, irqs = 0, last_irq = 0, t1;
    int divs[4] = '{div0_cycles, div1_cycles, div2_cycles, div3_cycles};

    always #50 clk_i = ~clk_i;

    gated_modulo_timer8 gated_modulo_timer8_i (.clk_i(clk_i), .rst_i(rst_i),
        .ce_rst_i(ce_rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .data_buffer_i(wdat), .data_buffer_o(data_buffer_o), .rd_valid_o(rd_valid_o),
        .gate_input_pin_i(gate), .timer_irq_request_o(irq),
        .timer_count_value_o(timer_count_value_o));
    gmt_gate_source gmt_gate_source_i (.clk_i(clk_i), .start_i(g_start),
        .active_high_i(g_high), .width_i(g_width), .gate_o(gate));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // The timeout ceiling leaves headroom over the longest clock select run.
    // The interrupt pin is sampled at the falling edge, where it has settled.
    always @(negedge clk_i) begin
        cycles++;
        if (!rst_i && irq === 1'b1) begin
            irqs++;
            last_irq = cycles;
        end
        if (cycles == 110000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdat = d;
        wr_i = 1;
        @(negedge clk_i);
        wr_i = 0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        rd_i = 1;
        @(negedge clk_i);
        rd_i = 0;
        for (int i = 0; i < 3 && rd_valid_o !== 1'b1; i++) @(negedge clk_i);
        d = (rd_valid_o === 1'b1) ? data_buffer_o : 8'hxx;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        check(what, {24'h000000, exp}, {24'h000000, d});
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = irqs;
        for (int i = 0; i < lim && irqs == n; i++) @(negedge clk_i);
        check("irq arrival", 1, irqs - n);
    endtask

    // Returns a few cycles before the gate closes so the close request is not missed.
    task automatic pulse(input int w);
        @(negedge clk_i);
        g_width = w[15:0];
        g_start = 1;
        @(negedge clk_i);
        g_start = 0;
        repeat (w - 5) @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 0;
        rdchk(addr_match, 8'hff, "match reset");
        rdchk(addr_clkrun, 8'h00, "clkrun reset");
        rdchk(addr_mode, 8'h00, "mode reset");
        rdchk(8'h00, 8'h00, "unmapped");
        wr(addr_match, 8'h01);
        rdchk(addr_match, 8'h01, "match rw");
        for (int s = 0; s < 4; s++) begin
            wr(addr_clkrun, 8'h08 | s[7:0]);
            wait_irq(3 * divs[s]);
            t1 = last_irq;
            wait_irq(3 * divs[s]);
            check("irq period", 2 * divs[s], last_irq - t1);
        end
        $display("test clock select done");
        wr(addr_match, 8'hff);
        wr(addr_clkrun, 8'h08);
        repeat (350) @(negedge clk_i);
        wr(addr_clkrun, 8'h00);
        rd(addr_count, cnt);
        check("count run", 1, cnt inside {8'h03, 8'h04});
        repeat (300) @(negedge clk_i);
        rdchk(addr_count, cnt, "count held");
        check("count pin", {24'h000000, cnt}, {24'h000000, timer_count_value_o});
        wr(addr_clkrun, 8'h04);
        repeat (150) @(negedge clk_i);
        rdchk(addr_count, 8'h00, "count clear");
        rdchk(addr_clkrun, 8'h00, "clear bit");
        $display("test run and clear done");
        wr(addr_match, 8'h02);
        wr(addr_mode, 8'h03);
        rdchk(addr_mode, 8'h03, "mode rw");
        wr(addr_clkrun, 8'h08);
        t1 = irqs;
        pulse(25650);
        check("overflow irq", 1, irqs - t1);
        wait_irq(20);
        rdchk(addr_mode, 8'h0b, "overflow flag");
        rd(addr_count, cnt);
        check("gate width", 1, cnt inside {8'h00, 8'h01});
        @(negedge clk_i);
        ce_rst_i = 1;
        @(negedge clk_i);
        ce_rst_i = 0;
        rdchk(addr_mode, 8'h03, "ce mode");
        rdchk(addr_match, 8'h02, "ce match");
        rdchk(addr_clkrun, 8'h08, "ce clkrun");
        $display("test gate overflow done");
        wr(addr_mode, 8'h05);
        g_high = 0;
        repeat (5) @(negedge clk_i);
        wr(addr_clkrun, 8'h0c);
        repeat (150) @(negedge clk_i);
        t1 = irqs;
        pulse(1000);
        check("no match irq", 0, irqs - t1);
        wait_irq(20);
        rd(addr_count, cnt);
        check("low pulse", 1, cnt inside {8'h09, 8'h0a, 8'h0b});
        $display("test gate polarity done");
        give_verdict();
    end
endmodule

// ==== verification/gmt_gate_source.sv ====
// External pulse source for the timer gate pin.
// Assumes the bench starts a pulse with a one-cycle start strobe.
`timescale 1ns/1ps
module gmt_gate_source (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic active_high_i,
    input wire logic [15:0] width_i,
    output logic gate_o
);
    logic [15:0] left_q = 16'h0000;
    // Changes on the rising edge like a flop, so the timer sees a clean level.
    always @(posedge clk_i) begin
        left_q <= start_i ? width_i : left_q - {15'h0000, left_q != 16'h0000};
    end
    assign gate_o = (left_q != 16'h0000) ? active_high_i : !active_high_i;
endmodule

// ==== verilog/gated_modulo_timer8.sv ====
// Gated modulo timer: 8-bit counter of a selectable basic clock, modulo or
// external gate measurement mode, with register access via the data buffer.
// Assumes the CPU side presents synchronous strobes and the gate pin is
// already synchronous to clk_i.
// Summary of operation
// - Two-bit select picks 100, 10, 2 or 1 kHz basic clock.
// - 8-bit counter counts ticks; modulo match raises interrupt request.
// - Writing 1 to clear bit zeroes counter; bit always reads 0.
// - Run enable bit starts or stops counting.
// - Clock select register resets to zero; CE reset keeps it.
// - Mode bit 0 selects modulo or gate counter mode.
// - Mode bit 1 picks the gate opening edge.
// - Mode bit 2 picks the gate closing edge.
// - Each edge is selectable as rising or falling.
// - Mode bit 3 records counter overflow.
// - Counter overflow raises the interrupt request.
// - In gate mode the closing edge raises the interrupt request.
// - Counting needs run enable, and in gate mode also gate open.
// - In gate mode a modulo match raises no interrupt.
// - Match register resets to all ones; CE reset keeps it.
// - CPU reads counter and reads or writes match value.
// - Start takes effect at next tick; stop takes effect at once.
// - Counter clear is aligned to the basic clock.
`timescale 1ns/1ps
module gated_modulo_timer8 (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] data_buffer_i,
    output logic [7:0] data_buffer_o,
    output logic rd_valid_o,
    input wire logic gate_input_pin_i,
    output logic timer_irq_request_o,
    output logic [7:0] timer_count_value_o
);
    import gmt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and decode.

    logic [3:0] clkrun_q;
    logic [2:0] mode_q;
    logic overflow_flag_q;
    logic [7:0] timer_match_value_q;
    logic [7:0] count_q;
    logic clear_pend_q;
    logic gate_open_q;
    logic gate_prev_q;
    logic tick;

    wire wr_match = wr_i && (addr_i == addr_match);
    wire wr_clkrun = wr_i && (addr_i == addr_clkrun);
    wire wr_mode = wr_i && (addr_i == addr_mode);
    wire run_enable = clkrun_q[run_enable_bit];
    wire gate_mode_select = mode_q[gate_mode_bit];
    wire gate_open_edge = mode_q[open_edge_bit];
    wire gate_close_edge = mode_q[close_edge_bit];
    wire clk_sel_hi = clkrun_q[clk_sel_hi_bit];
    wire clk_sel_lo = clkrun_q[clk_sel_lo_bit];
    wire clk_sel_t sel = clk_sel_t'({clk_sel_hi, clk_sel_lo});

    ////////////////////////////////////////////////////////////////////////
    // Gate edge detection. Edge select bit 1 means rising, 0 falling.

    wire rise = gate_input_pin_i && !gate_prev_q;
    wire fall = !gate_input_pin_i && gate_prev_q;
    wire open_ev = gate_open_edge ? rise : fall;
    wire close_ev = gate_close_edge ? rise : fall;
    wire gate_ok = !gate_mode_select || gate_open_q;
    // Stopping is immediate because the enable is sampled at each tick.
    wire count_en = tick && run_enable && gate_ok;
    wire at_top = (count_q == 8'hff);
    wire match = (count_q == timer_match_value_q);
    wire ovf_ev = count_en && at_top;
    wire match_irq = count_en && !gate_mode_select && match;
    wire close_irq = gate_mode_select && gate_open_q && close_ev;
    wire irq_d = match_irq || ovf_ev || close_irq;

    logic [7:0] rd_mux;
    assign rd_mux = (addr_i == addr_match) ? timer_match_value_q :
                    (addr_i == addr_clkrun) ? {4'h0, run_enable, 1'b0, clk_sel_hi, clk_sel_lo} :
                    (addr_i == addr_mode) ? {4'h0, overflow_flag_q, mode_q} :
                    (addr_i == addr_count) ? count_q : 8'h00;

    gmt_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(sel),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers: full reset only, CE reset retains them.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clkrun_q <= clkrun_reset;
            mode_q <= mode_reset[2:0];
            timer_match_value_q <= match_reset;
        end else begin
            if (wr_clkrun) begin
                clkrun_q <= {data_buffer_i[3], 1'b0, data_buffer_i[1:0]};
            end
            if (wr_mode) begin
                mode_q <= data_buffer_i[2:0];
            end
            if (wr_match) begin
                timer_match_value_q <= data_buffer_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overflow flag: hardware set wins over a software write of zero.

    always_ff @(posedge clk_i) begin
        if (rst_i || ce_rst_i) begin
            overflow_flag_q <= 1'b0;
        end else if (ovf_ev) begin
            overflow_flag_q <= 1'b1;
        end else if (wr_mode) begin
            overflow_flag_q <= data_buffer_i[overflow_bit];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate state.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_prev_q <= 1'b0;
            gate_open_q <= 1'b0;
        end else begin
            gate_prev_q <= gate_input_pin_i;
            if (!gate_mode_select) begin
                gate_open_q <= 1'b0;
            end else if (gate_open_q && close_ev) begin
                gate_open_q <= 1'b0;
            end else if (!gate_open_q && open_ev) begin
                gate_open_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter. A clear request waits for the next basic tick so that the
    // restart lines up with the basic clock.

    always_ff @(posedge clk_i) begin
        if (rst_i || ce_rst_i) begin
            count_q <= 8'h00;
            clear_pend_q <= 1'b0;
        end else begin
            if (wr_clkrun && data_buffer_i[count_clear_bit]) begin
                clear_pend_q <= 1'b1;
            end else if (tick) begin
                clear_pend_q <= 1'b0;
            end
            if (tick && clear_pend_q) begin
                count_q <= 8'h00;
            end else if (match_irq) begin
                count_q <= 8'h00;
            end else if (count_en) begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_irq_request_o <= 1'b0;
            data_buffer_o <= 8'h00;
            rd_valid_o <= 1'b0;
            timer_count_value_o <= 8'h00;
        end else begin
            timer_irq_request_o <= irq_d;
            rd_valid_o <= rd_i;
            data_buffer_o <= rd_i ? rd_mux : data_buffer_o;
            timer_count_value_o <= count_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_match_irq;
        @(posedge clk_i) disable iff (rst_i)
        (tick && run_enable && !gate_mode_select && match && !clear_pend_q && !ce_rst_i)
            |=> timer_irq_request_o && count_q == 8'h00;
    endproperty
    match_irq_a: assert property (p_match_irq) else $error("match irq missing");

    stopped_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run_enable && !clear_pend_q && !ce_rst_i) |=> $stable(count_q))
        else $error("counter moved while stopped");

    clear_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == addr_clkrun) |=> !data_buffer_o[count_clear_bit])
        else $error("clear bit read as one");

    ovf_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovf_ev && !ce_rst_i) |=> overflow_flag_q && timer_irq_request_o)
        else $error("overflow not recorded");

    gate_no_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (gate_mode_select && !close_irq && !ovf_ev) |=> !timer_irq_request_o)
        else $error("irq in gate mode");

    close_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (gate_mode_select && gate_open_q && close_ev) |=> timer_irq_request_o && !gate_open_q)
        else $error("gate close irq missing");

    gated_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (gate_mode_select && !gate_open_q && !clear_pend_q && !ce_rst_i) |=> $stable(count_q))
        else $error("count with gate shut");

    clear_aligned_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (clear_pend_q && !tick && !ce_rst_i) |=> $stable(count_q) || count_q == 8'h00)
        else $error("clear not tick aligned");

    match_reset_a: assert property (@(posedge clk_i)
        rst_i |=> timer_match_value_q == match_reset && clkrun_q == clkrun_reset)
        else $error("bad reset value");

    match_cov_c: cover property (@(posedge clk_i) match_irq);
    close_cov_c: cover property (@(posedge clk_i) close_irq);
    ovf_cov_c: cover property (@(posedge clk_i) ovf_ev);
endmodule

// ==== verilog/gmt_tick_gen.sv ====
// Basic clock tick generator: four divided enable strobes from the system clock.
// Assumes one synchronous clock domain; picks one strobe by the select code.
`timescale 1ns/1ps
module gmt_tick_gen
    import gmt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire gmt_pkg::clk_sel_t sel_i,
    output logic tick_o
);
    import gmt_pkg::*;

    function automatic logic [div_width-1:0] wrap_at(input int unsigned n);
        wrap_at = div_width'(n - 1);
    endfunction

    logic [div_width-1:0] cnt0_q, cnt1_q, cnt2_q, cnt3_q;
    wire w0 = (cnt0_q == wrap_at(div0_cycles));
    wire w1 = (cnt1_q == wrap_at(div1_cycles));
    wire w2 = (cnt2_q == wrap_at(div2_cycles));
    wire w3 = (cnt3_q == wrap_at(div3_cycles));
    logic pick_d;

    // The dividers free-run so a select change takes effect at the next
    // tick of the new rate, with up to one new clock of error.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt0_q <= '0;
            cnt1_q <= '0;
            cnt2_q <= '0;
            cnt3_q <= '0;
        end else begin
            cnt0_q <= w0 ? '0 : cnt0_q + 1'b1;
            cnt1_q <= w1 ? '0 : cnt1_q + 1'b1;
            cnt2_q <= w2 ? '0 : cnt2_q + 1'b1;
            cnt3_q <= w3 ? '0 : cnt3_q + 1'b1;
        end
    end

    always_comb begin
        case (sel_i)
            sel_100k: pick_d = w0;
            sel_10k: pick_d = w1;
            sel_2k: pick_d = w2;
            sel_1k: pick_d = w3;
            default: pick_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= pick_d;
        end
    end
endmodule
